// ==== rtl/cma_pkg.sv ====
// package: operation codes, operand forms, cycle counts and carrier structs for the alu datapath
package cma_pkg;

  typedef enum logic [4:0] {
    CMA_OP_AND   = 5'h00,
    CMA_OP_OR    = 5'h01,
    CMA_OP_XOR   = 5'h02,
    CMA_OP_NOT   = 5'h03,
    CMA_OP_NEG   = 5'h04,
    CMA_OP_NORMALIZE_SHIFT  = 5'h05,
    CMA_OP_DIVB  = 5'h06,
    CMA_OP_DIVW  = 5'h07,
    CMA_OP_MULB  = 5'h08,
    CMA_OP_MULW  = 5'h09
  } cma_op_t;

  // where the second operand comes from
  typedef enum logic [1:0] {
    CMA_SRC_ACC = 2'h0,
    CMA_SRC_REG = 2'h1,
    CMA_SRC_MEM = 2'h2,
    CMA_SRC_IMM = 2'h3
  } cma_src_t;

  typedef enum logic [1:0] {
    CMA_SZ_BYTE = 2'h0,
    CMA_SZ_WORD = 2'h1,
    CMA_SZ_LONG = 2'h2
  } cma_size_t;

  typedef struct packed {
    cma_op_t    op;
    cma_src_t   src;
    cma_size_t  size;
    logic [31:0] acc;
    logic [31:0] opnd;
    logic [7:0]  addr_corr;
    logic        carry_in;
  } cma_req_t;

  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] dest;
    logic        acc_we;
    logic        dest_we;
    logic [7:0]  gen_reg_zero;
    logic        gen_reg_zero_we;
    logic        flag_n;
    logic        flag_z;
    logic        flag_v;
    logic        flag_c;
    logic [3:0]  flag_we;
    logic [1:0]  mem_accesses;
    logic        rmw;
  } cma_rsp_t;

  // flag write-enable bit positions: {n, z, v, c}
  localparam int unsigned CMA_FWE_N = 3;
  localparam int unsigned CMA_FWE_Z = 2;
  localparam int unsigned CMA_FWE_V = 1;
  localparam int unsigned CMA_FWE_C = 0;

  localparam logic [7:0] CMA_DIVB_ACC_ZERO = 8'h03;
  localparam logic [7:0] CMA_DIVB_ACC_OVF  = 8'h07;
  localparam logic [7:0] CMA_DIVB_ACC_NORM = 8'h0f;
  localparam logic [7:0] CMA_DIVB_REG_ZERO = 8'h04;
  localparam logic [7:0] CMA_DIVB_REG_OVF  = 8'h08;
  localparam logic [7:0] CMA_DIVB_REG_NORM = 8'h10;
  localparam logic [7:0] CMA_DIVW_REG_ZERO = 8'h04;
  localparam logic [7:0] CMA_DIVW_REG_OVF  = 8'h07;
  localparam logic [7:0] CMA_DIVW_REG_NORM = 8'h16;
  localparam logic [7:0] CMA_DIVB_MEM_ZERO = 8'h06;
  localparam logic [7:0] CMA_DIVB_MEM_OVF  = 8'h09;
  localparam logic [7:0] CMA_DIVB_MEM_NORM = 8'h13;
  localparam logic [7:0] CMA_DIVW_MEM_ZERO = 8'h06;
  localparam logic [7:0] CMA_DIVW_MEM_OVF  = 8'h08;
  localparam logic [7:0] CMA_DIVW_MEM_NORM = 8'h1a;
  localparam logic [7:0] CMA_MULB_ACC_ZERO = 8'h03;
  localparam logic [7:0] CMA_MULB_ACC_NZ   = 8'h07;
  localparam logic [7:0] CMA_MULB_REG_ZERO = 8'h04;
  localparam logic [7:0] CMA_MULB_REG_NZ   = 8'h08;
  localparam logic [7:0] CMA_MULW_ACC_ZERO = 8'h03;
  localparam logic [7:0] CMA_MULW_ACC_NZ   = 8'h0b;
  localparam logic [7:0] CMA_MULW_REG_ZERO = 8'h04;
  localparam logic [7:0] CMA_MULW_REG_NZ   = 8'h0c;
  localparam logic [7:0] CMA_MUL_MEM_ZERO  = 8'h05;
  localparam logic [7:0] CMA_MULB_MEM_NZ   = 8'h09;
  localparam logic [7:0] CMA_MULW_MEM_NZ   = 8'h0d;
  localparam logic [7:0] CMA_LONG_REG_CYC  = 8'h06;
  localparam logic [7:0] CMA_LONG_MEM_CYC  = 8'h07;
  localparam logic [7:0] CMA_LOG_ACC_CYC   = 8'h02;
  localparam logic [7:0] CMA_LOG_REG_CYC   = 8'h03;
  localparam logic [7:0] CMA_LOG_MEM_CYC   = 8'h04;
  localparam logic [7:0] CMA_RMW_MEM_CYC   = 8'h05;
  localparam logic [7:0] CMA_NORMALIZE_SHIFT_ZERO_CYC = 8'h04;
  localparam logic [7:0] CMA_NORMALIZE_SHIFT_BASE_CYC = 8'h06;

  localparam logic [1:0] CMA_ACC_ONE = 2'h1;
  localparam logic [1:0] CMA_ACC_TWO = 2'h2;

endpackage

// ==== rtl/cma_divider.sv ====
// combinational unsigned divide of the accumulator by a byte or word divisor
`timescale 1ns/100ps
`default_nettype none
module cma_divider (
  input  wire logic [31:0] dividend_i,
  input  wire logic [15:0] divisor_i,
  input  wire logic        word_i,
  output logic      [15:0] quot_o,
  output logic      [15:0] rem_o,
  output logic             zero_o,
  output logic             ovf_o
);
  logic [31:0] q_full;
  logic [31:0] r_full;
  logic [31:0] dvsr;

  always_comb begin
    dvsr = word_i ? {16'h0000, divisor_i} : {24'h000000, divisor_i[7:0]};
    // divide by zero is reported as overflow and writes no result
    if (dvsr == 32'h0000_0000) begin
      q_full = 32'h0000_0000;
      r_full = 32'h0000_0000;
    end else begin
      q_full = word_i ? dividend_i / dvsr : {16'h0000, dividend_i[15:0]} / dvsr;
      r_full = word_i ? dividend_i % dvsr : {16'h0000, dividend_i[15:0]} % dvsr;
    end
    quot_o = q_full[15:0];
    rem_o  = r_full[15:0];
    ovf_o  = (dvsr == 32'h0000_0000) || (word_i ? (q_full[31:16] != 16'h0000) : (q_full[15:8] != 8'h00));
    zero_o = !ovf_o && (word_i ? (q_full[15:0] == 16'h0000) : (q_full[7:0] == 8'h00));
  end
endmodule
`default_nettype wire

// ==== rtl/cma_normalizer.sv ====
// leading-one search for the normalize operation
`timescale 1ns/100ps
`default_nettype none
module cma_normalizer #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic [WIDTH-1:0] value_i,
  output logic      [WIDTH-1:0] shifted_o,
  output logic      [7:0]       count_o,
  output logic                  all_zero_o
);
  logic [7:0] cnt;

  always_comb begin
    cnt = 8'h00;
    // scan from lsb upward so the highest set bit sets the final count
    for (int i = 0; i < WIDTH; i++) begin
      if (value_i[i]) begin
        cnt = 8'(WIDTH - 1 - i);
      end
    end
    all_zero_o = (value_i == '0);
    count_o    = all_zero_o ? 8'h00 : cnt;
    shifted_o  = value_i << count_o;
  end
endmodule
`default_nettype wire

// ==== rtl/cma_alu.sv ====
// multiply/divide/logic datapath with data-dependent cycle timing
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module cma_alu
  import cma_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              start_i,
  input  wire cma_pkg::cma_req_t req_i,
  output logic                   busy_o,
  output logic                   done_o,
  output cma_pkg::cma_rsp_t      rsp_o,
  output logic [7:0]             cycles_o
);
  import cma_pkg::*;

  // ------------------------------------------------------------
  // reset synchroniser
  // ------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ------------------------------------------------------------
  // arithmetic helpers
  // ------------------------------------------------------------
  logic [15:0] div_quot;
  logic [15:0] div_rem;
  logic        div_zero;
  logic        div_ovf;
  logic [31:0] div_dividend;
  logic [15:0] div_divisor;
  logic [31:0] nrm_shifted;
  logic [7:0]  nrm_count;
  logic        nrm_zero;

  cma_divider u_div (
    .dividend_i (div_dividend),
    .divisor_i  (div_divisor),
    .word_i     (req_i.op == CMA_OP_DIVW),
    .quot_o     (div_quot),
    .rem_o      (div_rem),
    .zero_o     (div_zero),
    .ovf_o      (div_ovf)
  );

  cma_normalizer #(.WIDTH(32)) u_nrm (
    .value_i    (req_i.acc),
    .shifted_o  (nrm_shifted),
    .count_o    (nrm_count),
    .all_zero_o (nrm_zero)
  );

  // sign bit of a result of the given size
  function automatic logic msb_of(input logic [31:0] v, input cma_size_t sz);
    case (sz)
      CMA_SZ_BYTE: msb_of = v[7];
      CMA_SZ_WORD: msb_of = v[15];
      default:     msb_of = v[31];
    endcase
  endfunction

  function automatic logic [31:0] mask_of(input logic [31:0] v, input cma_size_t sz);
    case (sz)
      CMA_SZ_BYTE: mask_of = {24'h000000, v[7:0]};
      CMA_SZ_WORD: mask_of = {16'h0000, v[15:0]};
      default:     mask_of = v;
    endcase
  endfunction

  // ------------------------------------------------------------
  // combinational result and cycle count
  // ------------------------------------------------------------
  cma_rsp_t    res;
  logic [7:0]  cyc;
  logic [31:0] lhs;
  logic [31:0] lres;
  logic [32:0] neg_full;
  logic [15:0] mul_a;
  logic [15:0] mul_b;
  logic        mem;

  always_comb begin
    res          = '0;
    cyc          = CMA_LOG_ACC_CYC;
    lres         = '0;
    neg_full     = '0;
    mul_a        = '0;
    mul_b        = '0;
    mem          = (req_i.src == CMA_SRC_MEM);
    lhs          = req_i.acc;
    div_dividend = req_i.acc;
    div_divisor  = req_i.opnd[15:0];
    res.acc      = req_i.acc;
    res.dest     = req_i.opnd;
    if (req_i.src == CMA_SRC_ACC && req_i.size == CMA_SZ_WORD) begin
      lhs = {16'h0000, req_i.acc[31:16]};
    end
    case (req_i.op)
      CMA_OP_AND, CMA_OP_OR, CMA_OP_XOR: begin
        case (req_i.op)
          CMA_OP_AND: lres = lhs & req_i.opnd;
          CMA_OP_OR:  lres = lhs | req_i.opnd;
          default:    lres = lhs ^ req_i.opnd;
        endcase
        if (req_i.src == CMA_SRC_ACC) begin
          lres = lhs & req_i.acc;
          if (req_i.op == CMA_OP_OR) lres = lhs | req_i.acc;
          if (req_i.op == CMA_OP_XOR) lres = lhs ^ req_i.acc;
        end
        lres          = mask_of(lres, req_i.size);
        res.acc       = lres;
        res.acc_we    = 1'b1;
        res.flag_n    = msb_of(lres, req_i.size);
        res.flag_z    = (lres == 32'h0000_0000);
        res.flag_v    = 1'b0;
        res.flag_c    = req_i.carry_in;
        res.flag_we   = 4'b1110;
        if (req_i.size == CMA_SZ_LONG) begin
          cyc = mem ? CMA_LONG_MEM_CYC + req_i.addr_corr : CMA_LONG_REG_CYC;
          res.mem_accesses = mem ? CMA_ACC_ONE : 2'h0;
        end else begin
          cyc = mem ? CMA_LOG_MEM_CYC + req_i.addr_corr
              : (req_i.src == CMA_SRC_REG ? CMA_LOG_REG_CYC : CMA_LOG_ACC_CYC);
          res.mem_accesses = mem ? CMA_ACC_ONE : 2'h0;
        end
      end
      CMA_OP_NOT: begin
        // the accumulator form inverts the accumulator itself
        lhs          = (req_i.src == CMA_SRC_ACC) ? req_i.acc : req_i.opnd;
        lres         = mask_of(~lhs, req_i.size);
        res.acc_we   = (req_i.src == CMA_SRC_ACC);
        res.dest_we  = !res.acc_we;
        res.acc      = res.acc_we ? lres : req_i.acc;
        res.dest     = lres;
        res.flag_n   = msb_of(lres, req_i.size);
        res.flag_z   = (lres == 32'h0000_0000);
        res.flag_c   = req_i.carry_in;
        res.flag_we  = 4'b1110;
        res.rmw      = mem;
        res.mem_accesses = mem ? CMA_ACC_TWO : 2'h0;
        cyc = mem ? CMA_RMW_MEM_CYC + req_i.addr_corr
            : (req_i.src == CMA_SRC_REG ? CMA_LOG_REG_CYC : CMA_LOG_ACC_CYC);
      end
      CMA_OP_NEG: begin
        lhs          = (req_i.src == CMA_SRC_ACC) ? req_i.acc : req_i.opnd;
        neg_full     = 33'h0 - {1'b0, mask_of(lhs, req_i.size)};
        lres         = mask_of(neg_full[31:0], req_i.size);
        res.acc_we   = (req_i.src == CMA_SRC_ACC);
        res.dest_we  = !res.acc_we;
        res.acc      = res.acc_we ? lres : req_i.acc;
        res.dest     = lres;
        res.flag_n   = msb_of(lres, req_i.size);
        res.flag_z   = (lres == 32'h0000_0000);
        // overflow only when the operand is the most negative value
        res.flag_v   = msb_of(lres, req_i.size) && msb_of(lhs, req_i.size);
        res.flag_c   = (mask_of(lhs, req_i.size) != 32'h0000_0000);
        res.flag_we  = 4'b1111;
        res.rmw      = mem;
        res.mem_accesses = mem ? CMA_ACC_TWO : 2'h0;
        cyc = mem ? CMA_RMW_MEM_CYC + req_i.addr_corr
            : (req_i.src == CMA_SRC_REG ? CMA_LOG_REG_CYC : CMA_LOG_ACC_CYC);
      end
      CMA_OP_NORMALIZE_SHIFT: begin
        res.acc             = nrm_shifted;
        res.acc_we          = 1'b1;
        res.gen_reg_zero    = nrm_count;
        res.gen_reg_zero_we = 1'b1;
        res.flag_z          = nrm_zero;
        res.flag_we         = 4'b0100;
        cyc = nrm_zero ? CMA_NORMALIZE_SHIFT_ZERO_CYC : CMA_NORMALIZE_SHIFT_BASE_CYC + nrm_count;
      end
      CMA_OP_DIVB, CMA_OP_DIVW: begin
        if (req_i.src == CMA_SRC_ACC) begin
          div_dividend = {16'h0000, req_i.acc[15:0]};
          div_divisor  = {8'h00, req_i.acc[7:0]};
        end
        res.flag_v  = div_ovf;
        res.flag_c  = req_i.carry_in;
        res.flag_we = 4'b0010;
        if (!div_ovf) begin
          if (req_i.op == CMA_OP_DIVB) begin
            if (req_i.src == CMA_SRC_ACC) begin
              res.acc = {req_i.acc[31:16], div_rem[7:0], div_quot[7:0]};
            end else begin
              res.acc     = {req_i.acc[31:8], div_quot[7:0]};
              res.dest    = {24'h000000, div_rem[7:0]};
              res.dest_we = 1'b1;
            end
          end else begin
            res.acc     = {req_i.acc[31:16], div_quot};
            res.dest    = {16'h0000, div_rem};
            res.dest_we = 1'b1;
          end
          res.acc_we = 1'b1;
        end
        if (req_i.op == CMA_OP_DIVB) begin
          case (req_i.src)
            CMA_SRC_ACC: cyc = div_zero ? CMA_DIVB_ACC_ZERO : (div_ovf ? CMA_DIVB_ACC_OVF : CMA_DIVB_ACC_NORM);
            CMA_SRC_MEM: cyc = (div_zero ? CMA_DIVB_MEM_ZERO : (div_ovf ? CMA_DIVB_MEM_OVF : CMA_DIVB_MEM_NORM))
                               + req_i.addr_corr;
            default:     cyc = div_zero ? CMA_DIVB_REG_ZERO : (div_ovf ? CMA_DIVB_REG_OVF : CMA_DIVB_REG_NORM);
          endcase
        end else if (mem) begin
          cyc = (div_zero ? CMA_DIVW_MEM_ZERO : (div_ovf ? CMA_DIVW_MEM_OVF : CMA_DIVW_MEM_NORM))
                + req_i.addr_corr;
        end else begin
          cyc = div_zero ? CMA_DIVW_REG_ZERO : (div_ovf ? CMA_DIVW_REG_OVF : CMA_DIVW_REG_NORM);
        end
        if (mem) begin
          res.mem_accesses = (div_zero || div_ovf) ? CMA_ACC_ONE : CMA_ACC_TWO;
        end
      end
      CMA_OP_MULB: begin
        mul_a = {8'h00, req_i.src == CMA_SRC_ACC ? req_i.acc[15:8] : req_i.acc[7:0]};
        mul_b = {8'h00, req_i.src == CMA_SRC_ACC ? req_i.acc[7:0] : req_i.opnd[7:0]};
        res.acc    = {req_i.acc[31:16], mul_a * mul_b};
        res.acc_we = 1'b1;
        case (req_i.src)
          CMA_SRC_ACC: cyc = (mul_a[7:0] == 8'h00) ? CMA_MULB_ACC_ZERO : CMA_MULB_ACC_NZ;
          CMA_SRC_MEM: cyc = ((mul_b[7:0] == 8'h00) ? CMA_MUL_MEM_ZERO : CMA_MULB_MEM_NZ)
                             + req_i.addr_corr;
          default:     cyc = (mul_b[7:0] == 8'h00) ? CMA_MULB_REG_ZERO : CMA_MULB_REG_NZ;
        endcase
        res.mem_accesses = mem ? CMA_ACC_ONE : 2'h0;
      end
      CMA_OP_MULW: begin
        mul_a = (req_i.src == CMA_SRC_ACC) ? req_i.acc[31:16] : req_i.acc[15:0];
        mul_b = (req_i.src == CMA_SRC_ACC) ? req_i.acc[15:0] : req_i.opnd[15:0];
        res.acc    = {16'h0000, mul_a} * {16'h0000, mul_b};
        res.acc_we = 1'b1;
        case (req_i.src)
          CMA_SRC_ACC: cyc = (mul_a == 16'h0000) ? CMA_MULW_ACC_ZERO : CMA_MULW_ACC_NZ;
          CMA_SRC_MEM: cyc = ((mul_b == 16'h0000) ? CMA_MUL_MEM_ZERO : CMA_MULW_MEM_NZ)
                             + req_i.addr_corr;
          default:     cyc = (mul_b == 16'h0000) ? CMA_MULW_REG_ZERO : CMA_MULW_REG_NZ;
        endcase
        res.mem_accesses = mem ? CMA_ACC_ONE : 2'h0;
      end
      default: begin
        cyc = CMA_LOG_ACC_CYC;
      end
    endcase
  end

  // ------------------------------------------------------------
  // sequencer: holds the result until the counted cycles elapse
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CMA_ST_IDLE = 2'b00,
    CMA_ST_RUN  = 2'b01,
    CMA_ST_DONE = 2'b10
  } cma_state_t;

  cma_state_t  state_r;
  cma_state_t  state_nxt;
  logic [7:0]  cnt_r;
  logic [7:0]  cnt_nxt;
  logic [7:0]  cyc_r;
  logic [7:0]  cyc_nxt;
  cma_rsp_t    rsp_r;
  cma_rsp_t    rsp_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    cyc_nxt   = cyc_r;
    rsp_nxt   = rsp_r;
    case (state_r)
      CMA_ST_IDLE: begin
        if (start_i) begin
          rsp_nxt = res;
          cyc_nxt = cyc;
          // the start cycle itself counts as the first cycle
          cnt_nxt   = cyc - 8'h01;
          state_nxt = (cyc <= 8'h01) ? CMA_ST_DONE : CMA_ST_RUN;
        end
      end
      CMA_ST_RUN: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r <= 8'h01) begin
          state_nxt = CMA_ST_DONE;
        end
      end
      CMA_ST_DONE: begin
        state_nxt = CMA_ST_IDLE;
      end
      default: begin
        state_nxt = CMA_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= CMA_ST_IDLE;
      cnt_r   <= 8'h00;
      cyc_r   <= 8'h00;
      rsp_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      cyc_r   <= cyc_nxt;
      rsp_r   <= rsp_nxt;
    end
  end

  assign busy_o   = (state_r == CMA_ST_RUN);
  assign done_o   = (state_r == CMA_ST_DONE);
  assign rsp_o    = rsp_r;
  assign cycles_o = cyc_r;

endmodule
`default_nettype wire

// ==== tb/cma_alu_props.sv ====
// checker: timing and flag relations at the alu ports
`timescale 1ns/100ps
`default_nettype none
module cma_alu_chk
  import cma_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              nrst_i,
  input wire logic              start_i,
  input wire cma_pkg::cma_req_t req_i,
  input wire logic              busy_o,
  input wire logic              done_o,
  input wire cma_pkg::cma_rsp_t rsp_o,
  input wire logic [7:0]        cycles_o
);
  // ----
  // request in flight: {op, size} kept from the taking edge
  // ----
  logic       take;
  logic [6:0] q_r;
  logic [6:0] q_nxt;
  assign take = start_i && !busy_o && !done_o;
  always_comb q_nxt = take ? {req_i.op, req_i.size} : q_r;
  always_ff @(posedge ref_clk_i or negedge nrst_i)
    if (!nrst_i) q_r <= '0;
    else q_r <= q_nxt;
  // ----
  // properties
  // ----
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  done_bound_a: assert property (take |-> ##[1:300] done_o)
    else $error("request not completed in time");
  mulb_zero_a: assert property (take && req_i.op == CMA_OP_MULB && req_i.src == CMA_SRC_ACC
    && req_i.acc[15:8] == 8'h00 |=> cycles_o == 8'h03) else $error("byte multiply zero count wrong");
  mulb_nz_a: assert property (take && req_i.op == CMA_OP_MULB && req_i.src == CMA_SRC_ACC
    && req_i.acc[15:8] != 8'h00 |=> cycles_o == 8'h07) else $error("byte multiply count wrong");
  divb_ovf_a: assert property (take && req_i.op == CMA_OP_DIVB && req_i.src == CMA_SRC_ACC
    && req_i.acc[7:0] == 8'h00 |=> cycles_o == 8'h07) else $error("byte divide overflow count wrong");
  normalize_shift_zero_a: assert property (take && req_i.op == CMA_OP_NORMALIZE_SHIFT && req_i.acc == 32'h0
    |=> cycles_o == 8'h04) else $error("normalize zero count wrong");
  long_reg_a: assert property (take && req_i.size == CMA_SZ_LONG && req_i.src == CMA_SRC_REG
    && req_i.op inside {CMA_OP_AND, CMA_OP_OR, CMA_OP_XOR} |=> cycles_o == 8'h06) else $error("long logic count wrong");
  logic_flag_a: assert property (done_o && q_r[6:2] inside {CMA_OP_AND, CMA_OP_OR, CMA_OP_XOR, CMA_OP_NOT}
    |-> rsp_o.flag_we == 4'he && !rsp_o.flag_v) else $error("logic flags wrong");
  mul_flag_a: assert property (done_o && q_r[6:2] inside {CMA_OP_MULB, CMA_OP_MULW}
    |-> rsp_o.flag_we == 4'h0 && rsp_o.acc_we) else $error("multiply flags wrong");
  normalize_shift_msb_a: assert property (done_o && q_r[6:2] == CMA_OP_NORMALIZE_SHIFT && rsp_o.acc != 32'h0
    |-> rsp_o.acc[31] && rsp_o.gen_reg_zero_we) else $error("normalize result not left aligned");
  neg_carry_a: assert property (done_o && q_r == {CMA_OP_NEG, CMA_SZ_BYTE}
    |-> rsp_o.flag_c == ((rsp_o.acc_we ? rsp_o.acc[7:0] : rsp_o.dest[7:0]) != 8'h00)
    && rsp_o.flag_we == 4'hf) else $error("negate carry wrong");
endmodule
bind cma_alu cma_alu_chk u_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .start_i(start_i), .req_i(req_i),
  .busy_o(busy_o), .done_o(done_o), .rsp_o(rsp_o), .cycles_o(cycles_o));
`default_nettype wire

// ==== tb/tb_top.sv ====
// testbench: every alu operation with random operands against a reference model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import cma_pkg::*;
  logic        ref_clk_i, nrst_i, start_i, busy_o, done_o;
  cma_req_t    req_i;
  cma_rsp_t    rsp_o;
  logic [7:0]  cycles_o, e_cyc, e_g0;
  int          failures, compares, i, v;
  logic [15:0] seed;
  logic [31:0] a, b, r1, r2, e_acc, e_dest, e_mask, e_dmask;
  logic [3:0]  e_fl, e_fwe;
  logic [1:0]  e_mem;
  logic        e_we, e_wchk, e_dchk, e_mchk;
  // entries are {op, src, size}
  logic [8:0]  tab [22] = '{9'h00c, 9'h015, 9'h028, 9'h001, 9'h026, 9'h01a, 9'h030, 9'h031, 9'h040, 9'h041, 9'h052,
                            9'h060, 9'h064, 9'h068, 9'h075, 9'h079, 9'h080, 9'h084, 9'h088, 9'h091, 9'h095, 9'h099};
  // divide counts by form (acc byte, reg byte, mem byte, reg word, mem word) and result (zero, overflow, normal)
  localparam logic [7:0] DTAB [5][3] = '{'{8'h03, 8'h07, 8'h0f}, '{8'h04, 8'h08, 8'h10}, '{8'h06, 8'h09, 8'h13},
                                         '{8'h04, 8'h07, 8'h16}, '{8'h06, 8'h08, 8'h1a}};
  cma_alu dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .start_i(start_i), .req_i(req_i), .busy_o(busy_o),
               .done_o(done_o), .rsp_o(rsp_o), .cycles_o(cycles_o));
  always #12.5 ref_clk_i = ~ref_clk_i;
  // ----
  // helpers and reference model
  // ----
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic nxt(output logic [31:0] r);
    repeat (2) begin
      seed = lfsr(seed);
      r = {r[15:0], seed};
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic model(input logic [8:0] t, input logic [31:0] ia, input logic [31:0] ib, input logic [7:0] cr);
    logic [31:0] x, r, msb;
    longint      dd, dv, q, m;
    int          c, k, idx;
    logic        mem, ovf, zr, acc;
    mem = (t[3:2] == CMA_SRC_MEM);
    acc = (t[3:2] == CMA_SRC_ACC);
    e_mask = (t[1:0] == CMA_SZ_BYTE) ? 32'hff : (t[1:0] == CMA_SZ_WORD) ? 32'hffff : 32'hffff_ffff;
    msb = e_mask ^ (e_mask >> 1);
    x = acc ? (ia >> 16) : ib;
    {e_we, e_wchk, e_dchk, e_mchk} = 4'hc;
    {e_fwe, e_fl, e_g0, e_mem} = 18'h38000;
    k = (t[8:4] inside {CMA_OP_MULB, CMA_OP_DIVB}) ? 8 : 16;
    m = (64'h1 << k) - 1;
    case (t[8:4])
      CMA_OP_AND, CMA_OP_OR, CMA_OP_XOR: begin
        r = (t[8:4] == CMA_OP_AND) ? (ia & x) : (t[8:4] == CMA_OP_OR) ? (ia | x) : (ia ^ x);
        if (t[1:0] == CMA_SZ_LONG) e_cyc = mem ? 8'h07 + cr : 8'h06;
        else e_cyc = mem ? 8'h04 + cr : (t[3:2] == CMA_SRC_REG) ? 8'h03 : 8'h02;
      end
      CMA_OP_NOT, CMA_OP_NEG: begin
        r = (t[8:4] == CMA_OP_NOT) ? ~ia : 32'h0 - ia;
        e_cyc = 8'h02;
        if (t[8:4] == CMA_OP_NEG) e_fwe = 4'hf;
        if (t[8:4] == CMA_OP_NEG) e_fl[1:0] = {(ia & e_mask) == msb, (ia & e_mask) != 0};
      end
      CMA_OP_MULB, CMA_OP_MULW: begin
        dd = acc ? (ia >> k) & m : ia & m;
        dv = acc ? ia & m : ib & m;
        r = 32'(dd * dv);
        e_mask = (k == 8) ? 32'hffff : 32'hffff_ffff;
        e_fwe = 4'h0;
        e_cyc = (mem ? 8'h05 + cr : acc ? 8'h03 : 8'h04) + (((acc ? dd : dv) != 0) ? 8'(k / 2) : 8'h00);
      end
      CMA_OP_DIVB, CMA_OP_DIVW: begin
        dd = (k == 8) ? ia[15:0] : ia;
        dv = acc ? ia[7:0] : ib & m;
        q = (dv == 0) ? 0 : dd / dv;
        ovf = (dv == 0) || ((q >> k) != 0);
        zr = !ovf && q == 0;
        idx = (k == 16) ? (mem ? 4 : 3) : acc ? 0 : mem ? 2 : 1;
        e_cyc = DTAB[idx][zr ? 0 : ovf ? 1 : 2] + (mem ? cr : 8'h00);
        {e_fwe, e_fl[1], e_we, e_wchk, e_mchk} = {4'h2, ovf, !ovf, 1'b1, mem};
        e_mem = (ovf || zr) ? 2'h1 : 2'h2;
        r = acc ? {16'h0, 8'(dd % (dv + (dv == 0))), 8'(q)} : 32'(q);
        e_mask = acc ? 32'hffff : 32'(m);
        e_dchk = !acc && !ovf;
        e_dest = 32'(dd % (dv + (dv == 0)));
        e_dmask = 32'(m);
      end
      default: begin
        c = 0;
        while (c < 32 && ia[31 - c] == 1'b0) c++;
        e_fwe = 4'h4;
        e_fl[2] = (ia == 32'h0);
        r = ia << (c % 32);
        e_g0 = 8'(c % 32);
        e_cyc = (ia == 32'h0) ? 8'h04 : 8'h06 + 8'(c);
      end
    endcase
    e_acc = r;
    if (e_fwe[3]) e_fl[3:2] = {|(r & msb), (r & e_mask) == 0};
  endtask
  task automatic run(input logic [8:0] t, input logic [31:0] ia, input logic [31:0] ib, input logic [7:0] cr,
                     input bit hold);
    int lat;
    @(negedge ref_clk_i);
    req_i = {t, ia, ib, cr, ia[0]};
    model(t, ia, ib, cr);
    start_i = 1'b1;
    @(negedge ref_clk_i);
    lat = 1;
    // a held strobe while busy must be refused, so the changed operand must not show
    if (hold) req_i.acc = ~ia;
    else start_i = 1'b0;
    while (done_o !== 1'b1 && lat < 400) begin
      @(negedge ref_clk_i);
      lat++;
      start_i = 1'b0;
    end
    if (lat >= 400) chk("done_o", 32'(done_o), 32'h1);
    if (lat >= 400) give_verdict();
    chk("cycles_o", 32'(cycles_o), 32'(e_cyc));
    chk("latency", 32'(lat - int'(e_cyc)), 32'h0);
    chk("flag_we", 32'(rsp_o.flag_we), 32'(e_fwe));
    chk("flags", 32'({rsp_o.flag_n, rsp_o.flag_z, rsp_o.flag_v, rsp_o.flag_c} & e_fwe), 32'(e_fl));
    if (e_wchk) chk("acc_we", 32'(rsp_o.acc_we), 32'(e_we));
    if (e_wchk && e_we) chk("acc", rsp_o.acc & e_mask, e_acc & e_mask);
    if (e_dchk) chk("dest", rsp_o.dest & e_dmask, e_dest);
    if (e_mchk) chk("mem_accesses", 32'(rsp_o.mem_accesses), 32'(e_mem));
    if (t[8:4] == CMA_OP_NORMALIZE_SHIFT) chk("gen_reg_zero", 32'(rsp_o.gen_reg_zero), 32'(e_g0));
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    {ref_clk_i, nrst_i, start_i} = 3'h0;
    req_i = '0;
    seed = 16'hd84c;
    failures = 0;
    compares = 0;
    repeat (2) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    for (i = 0; i < 22; i++) begin
      for (v = 0; v < 5; v++) begin
        nxt(r1);
        nxt(r2);
        a = (v == 0) ? r1 : (v == 1) ? r1 & 32'h3f : (v == 2) ? r1 | 32'h0100_0100 : (v == 3) ? r1 & 32'h7fff : 32'h0;
        b = (v == 0 || v == 4) ? 32'h0 : (v == 2) ? 32'h1 : r2 | 32'h80;
        run(tab[i], a, b, r2[7:0] & 8'h0f, v == 3);
      end
      $display("test %0d finished, failures %0d", i, failures);
    end
    // reset in the middle of a long divide
    @(negedge ref_clk_i);
    req_i = {tab[15], r1, r2 | 32'h80, 8'h03, 1'b0};
    start_i = 1'b1;
    @(negedge ref_clk_i);
    start_i = 1'b0;
    nrst_i = 1'b0;
    @(negedge ref_clk_i);
    chk("idle after reset", {busy_o, done_o, cycles_o}, 32'h0);
    nrst_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    run(tab[14], r1, r2 | 32'h80, 8'h00, 1'b0);
    $display("test reset finished, failures %0d", failures);
    give_verdict();
  end
endmodule
`default_nettype wire
